// ### ics_pkg.sv
/*
 Shared constants and types of the internal clock select switch.
 Assumes one 100 MHz system clock and APB register access.
*/
// Function
// - RC mode: pin two drives clock divided by four
// - RC with I/O: pin two is general I/O
// - Internal clock-out: pin one I/O, pin two clock/4
// - Internal with I/O: both pins general I/O
// - Fast oscillator on: select nonzero and scs/two-speed
// - Trim is 5-bit signed, resets zero, upper zero
// - Trim 0 calibrated, 01111 max, 10000 min
// - Trim drifts frequency; no completion flag exists
// - Trim never touches slow oscillator timing
// - Slow oscillator times power-up, watchdog, fail-safe
// - Slow oscillator on for slow select or timers
// - Two read-only stable bits, fast and slow
// - Select field resets to 110, 4 MHz
// - Switch: start, falling edge, hold low, rising edge
// - Postscaled fast switches need no start-up wait
// - Source select 0 config mode, 1 internal
// - Any reset clears source select
// - Automatic switches keep scs; status shows source
// - Select codes 111 fast, 110..001 fast divided, 000 slow
// - Startup status 1 external, 0 internal
// - Pin mode comes from config oscillator field

package ics_pkg;

// ==========================================================
// Register map
localparam logic [11:0] ICS_OFS_CTL = 12'h000;
localparam logic [11:0] ICS_OFS_TRIM = 12'h004;
localparam logic [11:0] ICS_OFS_CFG = 12'h008;

// ==========================================================
// Reset values and codes
localparam logic [2:0] ICS_SEL_RST = 3'h6;
localparam logic [2:0] ICS_SEL_SLOW = 3'h0;
localparam logic [2:0] ICS_SEL_FAST = 3'h7;
localparam logic [4:0] ICS_TRIM_RST = 5'h00;
localparam logic ICS_SCS_RST = 1'b0;
localparam logic [2:0] ICS_MODE_LP = 3'h0;
localparam logic [2:0] ICS_MODE_XT = 3'h1;
localparam logic [2:0] ICS_MODE_HS = 3'h2;
localparam logic [2:0] ICS_MODE_EC = 3'h3;
localparam logic [2:0] ICS_MODE_INTIO = 3'h4;
localparam logic [2:0] ICS_MODE_INTCLK = 3'h5;
localparam logic [2:0] ICS_MODE_RESISTOR_CAP_WITH_IO_MODE = 3'h6;
localparam logic [2:0] ICS_MODE_RC = 3'h7;
localparam int ICS_DIV_W = 6;

// ==========================================================
// Types
typedef struct packed {
	logic [2:0] sel;
	logic system_clock_source_select;
} ics_ctl_t;

typedef struct packed {
	logic fsm_en;
	logic wdt_en;
	logic power_up_timer_en;
	logic two_speed;
	logic [2:0] mode;
} ics_cfg_t;

localparam ics_cfg_t ICS_CFG_RST = 7'h05;

typedef struct packed {
	logic ext;
	logic [2:0] sel;
} ics_src_t;

typedef enum logic [1:0] {
	ICS_IDLE = 2'b00,
	ICS_WAIT_RDY = 2'b01,
	ICS_WAIT_FALL = 2'b10,
	ICS_WAIT_RISE = 2'b11
} ics_state_t;

endpackage

// ### ics_clock_select.sv
/*
 Internal clock select switch: APB registers, postscaler, glitch
 free source switch, divided clock output and pin muxing.
 Assumes oscillator clocks far below 50 MHz, sampled by clk.
*/
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module ics_clock_select #(
	parameter int DIV_W = ics_pkg::ICS_DIV_W
)(
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pin_one_in,
	input wire logic fast_osc_clk,
	input wire logic fast_osc_ready,
	input wire logic slow_osc_clk,
	input wire logic slow_osc_ready,
	input wire logic auto_internal,
	input wire logic gpio_one_out,
	input wire logic gpio_one_oe,
	input wire logic gpio_two_out,
	input wire logic gpio_two_oe,
	output logic sys_clk,
	output logic fast_osc_en,
	output logic slow_osc_en,
	output logic signed [4:0] trim_value,
	output logic pin_one_out,
	output logic pin_one_oe,
	output logic pin_two_out,
	output logic pin_two_oe
);

// ==========================================================
// Input synchronisers
logic [4:0] raw;
logic [4:0] sync_a_q;
logic [4:0] sync_b_q;
assign raw = {pin_one_in, fast_osc_clk, fast_osc_ready,
	slow_osc_clk, slow_osc_ready};

genvar g;
generate
	for (g = 0; g < 5; g++)
	begin : g_sync
		always_ff @(posedge clk)
		begin
			sync_a_q[g] <= srst ? 1'b0 : raw[g];
			sync_b_q[g] <= srst ? 1'b0 : sync_a_q[g];
		end
	end
endgenerate

logic ext_s, fast_s, fast_rdy_s, slow_s, slow_rdy_s;
assign ext_s = sync_b_q[4];
assign fast_s = sync_b_q[3];
assign fast_rdy_s = sync_b_q[2];
assign slow_s = sync_b_q[1];
assign slow_rdy_s = sync_b_q[0];

// ==========================================================
// Registers
ics_pkg::ics_ctl_t ctl_q, ctl_d;
ics_pkg::ics_cfg_t cfg_q, cfg_d;
logic [4:0] trim_q, trim_d;
logic [31:0] prdata_q, prdata_d;
logic fast_st_q, fast_st_d, slow_st_q, slow_st_d;
ics_pkg::ics_src_t cur_q, cur_d, tgt_q, tgt_d, tgt;
logic setup, wr, mapped, is_ctl, is_trim, is_cfg;

assign setup = psel && !penable;
assign wr = psel && penable && pwrite;
assign is_ctl = paddr == ics_pkg::ICS_OFS_CTL;
assign is_trim = paddr == ics_pkg::ICS_OFS_TRIM;
assign is_cfg = paddr == ics_pkg::ICS_OFS_CFG;
assign mapped = is_ctl || is_trim || is_cfg;
// Zero wait states keep the core's register access simple
assign pready = 1'b1;
assign pslverr = psel && penable && !mapped;

always_comb
begin
	ctl_d = ctl_q;
	cfg_d = cfg_q;
	trim_d = trim_q;
	prdata_d = prdata_q;
	if (wr && is_ctl)
		ctl_d = {pwdata[6:4], pwdata[0]};
	if (wr && is_trim)
		trim_d = pwdata[4:0];
	if (wr && is_cfg)
		cfg_d = pwdata[6:0];
	if (setup && is_ctl)
		prdata_d = {24'h0, 1'b0, ctl_q.sel, cur_q.ext,
			fast_st_q, slow_st_q, ctl_q.system_clock_source_select};
	else if (setup && is_trim)
		prdata_d = {27'h0, trim_q};
	else if (setup && is_cfg)
		prdata_d = {25'h0, cfg_q};
	else if (setup)
		prdata_d = 32'h0;
end

always_ff @(posedge clk)
begin
	ctl_q <= srst ? {ics_pkg::ICS_SEL_RST, ics_pkg::ICS_SCS_RST} :
		ctl_d;
	cfg_q <= srst ? ics_pkg::ICS_CFG_RST : cfg_d;
	trim_q <= srst ? ics_pkg::ICS_TRIM_RST : trim_d;
	prdata_q <= srst ? 32'h0 : prdata_d;
end

assign prdata = prdata_q;
// Signed code to the analog trim only; slow path never sees it
assign trim_value = signed'(trim_q);

// ==========================================================
// Postscaler divider chain
logic [DIV_W-1:0] div_q, div_d;
logic fast_prev_q;

always_comb
begin
	div_d = div_q;
	if (fast_s && !fast_prev_q)
		div_d = div_q + 1'b1;
end

always_ff @(posedge clk)
begin
	div_q <= srst ? '0 : div_d;
	fast_prev_q <= srst ? 1'b0 : fast_s;
end

// ==========================================================
// Source helpers
function automatic logic src_level(ics_pkg::ics_src_t s,
	logic [DIV_W-1:0] dv, logic e, logic f, logic sl);
	if (s.ext)
		return e;
	if (s.sel == ics_pkg::ICS_SEL_SLOW)
		return sl;
	if (s.sel == ics_pkg::ICS_SEL_FAST)
		return f;
	return dv[3'd6 - s.sel];
endfunction

function automatic logic fast_based(ics_pkg::ics_src_t s);
	return !s.ext && s.sel != ics_pkg::ICS_SEL_SLOW;
endfunction

logic int_mode, use_int, two_sp;
assign int_mode = cfg_q.mode == ics_pkg::ICS_MODE_INTIO ||
	cfg_q.mode == ics_pkg::ICS_MODE_INTCLK;
// Automatic requests steer the source but never write scs
assign use_int = ctl_q.system_clock_source_select || auto_internal || int_mode;
assign two_sp = cfg_q.two_speed;
assign tgt.ext = !use_int;
assign tgt.sel = use_int ? ctl_q.sel : ics_pkg::ICS_SEL_SLOW;

// ==========================================================
// Glitch free switch
ics_pkg::ics_state_t st_q, st_d;
logic sys_clk_q, sys_clk_d, cur_prev_q, new_prev_q;
logic cur_lvl, new_lvl, tgt_rdy, both_fast;

assign cur_lvl = src_level(cur_q, div_q, ext_s, fast_s, slow_s);
assign new_lvl = src_level(tgt_q, div_q, ext_s, fast_s, slow_s);
assign tgt_rdy = tgt_q.ext ||
	(tgt_q.sel == ics_pkg::ICS_SEL_SLOW ? slow_rdy_s : fast_rdy_s);
assign both_fast = fast_based(cur_q) && fast_based(tgt_q);

// A stopped new clock leaves the switch waiting in hold-low
always_comb
begin
	st_d = st_q;
	cur_d = cur_q;
	tgt_d = tgt_q;
	sys_clk_d = cur_lvl;
	fast_st_d = fast_st_q;
	slow_st_d = slow_st_q;
	unique case (st_q)
		ics_pkg::ICS_IDLE:
		begin
			fast_st_d = fast_rdy_s;
			slow_st_d = slow_rdy_s;
			if (tgt != cur_q)
			begin
				tgt_d = tgt;
				st_d = ics_pkg::ICS_WAIT_RDY;
			end
		end
		ics_pkg::ICS_WAIT_RDY:
			if (tgt_rdy || both_fast)
				st_d = ics_pkg::ICS_WAIT_FALL;
		ics_pkg::ICS_WAIT_FALL:
			if (cur_prev_q && !cur_lvl)
			begin
				sys_clk_d = 1'b0;
				st_d = ics_pkg::ICS_WAIT_RISE;
			end
		ics_pkg::ICS_WAIT_RISE:
		begin
			sys_clk_d = 1'b0;
			if (!new_prev_q && new_lvl)
			begin
				sys_clk_d = 1'b1;
				cur_d = tgt_q;
				fast_st_d = fast_rdy_s;
				slow_st_d = slow_rdy_s;
				st_d = ics_pkg::ICS_IDLE;
			end
		end
	endcase
end

always_ff @(posedge clk)
begin
	st_q <= srst ? ics_pkg::ICS_IDLE : st_d;
	cur_q <= srst ? {1'b1, ics_pkg::ICS_SEL_SLOW} : cur_d;
	tgt_q <= srst ? {1'b1, ics_pkg::ICS_SEL_SLOW} : tgt_d;
	sys_clk_q <= srst ? 1'b0 : sys_clk_d;
	fast_st_q <= srst ? 1'b0 : fast_st_d;
	slow_st_q <= srst ? 1'b0 : slow_st_d;
	cur_prev_q <= srst ? 1'b0 : cur_lvl;
	new_prev_q <= srst ? 1'b0 : new_lvl;
end

assign sys_clk = sys_clk_q;

// ==========================================================
// Oscillator enables
logic fast_en_q, fast_en_d, slow_en_q, slow_en_d, sel_slow;
logic busy;
assign sel_slow = ctl_q.sel == ics_pkg::ICS_SEL_SLOW;
assign busy = st_q != ics_pkg::ICS_IDLE;

always_comb
begin
	fast_en_d = (!sel_slow && (ctl_q.system_clock_source_select || two_sp)) ||
		fast_based(cur_q) || (busy && fast_based(tgt_q));
	slow_en_d = (sel_slow && (ctl_q.system_clock_source_select || two_sp)) ||
		cfg_q.power_up_timer_en || cfg_q.wdt_en || cfg_q.fsm_en ||
		(!cur_q.ext && cur_q.sel == ics_pkg::ICS_SEL_SLOW) ||
		(busy && !tgt_q.ext && tgt_q.sel == ics_pkg::ICS_SEL_SLOW);
end

always_ff @(posedge clk)
begin
	fast_en_q <= srst ? 1'b0 : fast_en_d;
	slow_en_q <= srst ? 1'b0 : slow_en_d;
end

assign fast_osc_en = fast_en_q;
assign slow_osc_en = slow_en_q;

// ==========================================================
// Divided clock output and pins
logic [1:0] div4_q, div4_d;
logic sys_prev_q;

always_comb
begin
	div4_d = div4_q;
	if (sys_clk_q && !sys_prev_q)
		div4_d = div4_q + 1'b1;
end

always_ff @(posedge clk)
begin
	div4_q <= srst ? 2'h0 : div4_d;
	sys_prev_q <= srst ? 1'b0 : sys_clk_q;
end

logic clk_out_pin, io_two;
assign clk_out_pin = cfg_q.mode == ics_pkg::ICS_MODE_RC ||
	cfg_q.mode == ics_pkg::ICS_MODE_INTCLK;
assign io_two = cfg_q.mode == ics_pkg::ICS_MODE_RESISTOR_CAP_WITH_IO_MODE ||
	cfg_q.mode == ics_pkg::ICS_MODE_INTIO ||
	cfg_q.mode == ics_pkg::ICS_MODE_EC;

always_comb
begin
	pin_one_out = int_mode ? gpio_one_out : 1'b0;
	pin_one_oe = int_mode ? gpio_one_oe : 1'b0;
	pin_two_out = 1'b0;
	pin_two_oe = 1'b0;
	if (clk_out_pin)
	begin
		pin_two_out = div4_q[1];
		pin_two_oe = 1'b1;
	end
	else if (io_two)
	begin
		pin_two_out = gpio_two_out;
		pin_two_oe = gpio_two_oe;
	end
end

// ==========================================================
// Assertions
default clocking cb @(posedge clk); endclocking
default disable iff (srst);

reset_values_a: assert property ($fell(srst) |->
	!ctl_q.system_clock_source_select && ctl_q.sel == ics_pkg::ICS_SEL_RST)
	else $error("control bits wrong after reset");
fast_enable_a: assert property (
	(!sel_slow && ctl_q.system_clock_source_select) |=> fast_osc_en)
	else $error("fast oscillator not enabled");
slow_enable_a: assert property (
	(cfg_q.wdt_en || cfg_q.power_up_timer_en || cfg_q.fsm_en) |=> slow_osc_en)
	else $error("slow oscillator not enabled");
hold_low_a: assert property (
	st_q == ics_pkg::ICS_WAIT_RISE |-> !sys_clk_q)
	else $error("clock not held low during switch");
connect_new_a: assert property (
	(st_q == ics_pkg::ICS_WAIT_RISE ##1 st_q == ics_pkg::ICS_IDLE)
	|-> sys_clk_q && cur_q == $past(tgt_q))
	else $error("new clock not connected");
status_read_a: assert property (
	(setup && is_ctl) |=> prdata[3] == $past(cur_q.ext))
	else $error("startup status wrong");
trim_upper_a: assert property (
	(setup && is_trim) |=> prdata[31:5] == 27'h0)
	else $error("trim upper bits not zero");
auto_keep_a: assert property (
	(auto_internal && !(wr && is_ctl)) |=> $stable(ctl_q.system_clock_source_select))
	else $error("automatic switch changed scs");
no_delay_a: assert property (
	(st_q == ics_pkg::ICS_WAIT_RDY && both_fast)
	|=> st_q == ics_pkg::ICS_WAIT_FALL)
	else $error("postscaled switch waited");
rc_divided_clock_output_a: assert property (
	cfg_q.mode == ics_pkg::ICS_MODE_RC |-> pin_two_oe &&
	pin_two_out == div4_q[1])
	else $error("divided clock not on pin two");
io_pins_a: assert property (
	cfg_q.mode == ics_pkg::ICS_MODE_INTIO |-> pin_two_oe ==
	gpio_two_oe && pin_one_oe == gpio_one_oe)
	else $error("pins not released to I/O");

endmodule

`default_nettype wire

// ### internal_clock_select_switch_tb.sv
/*
 Self-checking bench of the clock select switch over APB.
 Assumes a zero or short wait APB slave and slow oscillators.
*/
`timescale 1ns/1ns
`default_nettype none

module internal_clock_select_switch_tb;
// ==========================================================
// Signals
logic clk, srst, psel, penable, pwrite, pready, pslverr, sys_clk;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rdv;
logic pin_one_in, fast_osc_clk, fast_osc_ready, slow_osc_clk;
logic slow_osc_ready, auto_internal, fast_osc_en, slow_osc_en;
logic gpio_one_out, gpio_one_oe, gpio_two_out, gpio_two_oe;
logic pin_one_out, pin_one_oe, pin_two_out, pin_two_oe, errv;
logic signed [4:0] trim_value;
logic [7:0] osc_cnt;
logic [4:0] codes [3] = '{5'h0f, 5'h10, 5'h00};
logic [31:0] tmr [3] = '{32'h13, 32'h23, 32'h43};
int bad_count, compares;

ics_clock_select DUT (
	.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .pin_one_in, .fast_osc_clk, .fast_osc_ready,
	.slow_osc_clk, .slow_osc_ready, .auto_internal, .gpio_one_out,
	.gpio_one_oe, .gpio_two_out, .gpio_two_oe, .sys_clk, .fast_osc_en,
	.slow_osc_en, .trim_value, .pin_one_out, .pin_one_oe, .pin_two_out,
	.pin_two_oe
);

// ==========================================================
// Clocks
initial
begin
	clk = 1'h0;
	forever #5 clk = ~clk;
end

// Oscillators come from a counter so their edges sit on clk edges
always @(posedge clk)
begin
	osc_cnt <= osc_cnt + 8'h01;
	fast_osc_clk <= osc_cnt[2];
	pin_one_in <= osc_cnt[3];
	slow_osc_clk <= osc_cnt[5];
end

// ==========================================================
// Tasks
task conclude;
	if (bad_count == 0 && compares > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
endtask

task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	compares++;
	if (got !== exp)
	begin
		bad_count++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask

task automatic apb(input logic w, input logic [11:0] a,
	input logic [31:0] d);
	int n;
	n = 0;
	psel <= 1'h1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge clk);
	penable <= 1'h1;
	do
	begin
		@(posedge clk);
		n++;
	end
	while (pready !== 1'h1 && n < 50);
	rdv = prdata;
	errv = pslverr;
	psel <= 1'h0;
	penable <= 1'h0;
	@(posedge clk);
	if (n >= 50)
	begin
		bad_count++;
		conclude();
	end
endtask

task automatic wr(input logic [11:0] a, input logic [31:0] d);
	apb(1'h1, a, d);
	repeat (3) @(posedge clk);
endtask

task automatic rd_m(input logic [11:0] a, input logic [31:0] m,
	input logic [31:0] e);
	apb(1'h0, a, 32'h0);
	chk(rdv & m, e);
endtask

// Polls control until masked bits match; a switch waits on slow edges
task automatic wait_ctl(input logic [31:0] m, input logic [31:0] e);
	int n;
	n = 0;
	do
	begin
		apb(1'h0, ics_pkg::ICS_OFS_CTL, 32'h0);
		n++;
	end
	while ((rdv & m) !== e && n < 400);
	chk(rdv & m, e);
	if ((rdv & m) !== e)
		conclude();
endtask

// Counts system clock rises between two rises of the divided output
task automatic div_chk(input int exp);
	int n, k, c;
	logic p, s;
	n = 0;
	k = 0;
	c = 0;
	p = 1'h1;
	while (n < 3000 && !(p === 1'h0 && pin_two_out === 1'h1))
	begin
		p = pin_two_out;
		@(posedge clk);
		n++;
	end
	p = 1'h1;
	while (n < 3000 && !(p === 1'h0 && pin_two_out === 1'h1))
	begin
		p = pin_two_out;
		s = sys_clk;
		@(posedge clk);
		n++;
		c++;
		if (s === 1'h0 && sys_clk === 1'h1)
			k++;
	end
	// A divided clock that never rises again is a hang, not a pass
	if (!(p === 1'h0 && pin_two_out === 1'h1))
	begin
		bad_count++;
		conclude();
	end
	chk(k, 4);
	chk(c, exp);
endtask

// ==========================================================
// Sequence
initial
begin
	srst = 1'h1;
	psel = 1'h0;
	penable = 1'h0;
	pwrite = 1'h0;
	paddr = 12'h000;
	pwdata = 32'h0;
	osc_cnt = 8'h00;
	fast_osc_clk = 1'h0;
	slow_osc_clk = 1'h0;
	pin_one_in = 1'h0;
	fast_osc_ready = 1'h1;
	slow_osc_ready = 1'h1;
	auto_internal = 1'h0;
	gpio_one_out = 1'h0;
	gpio_one_oe = 1'h1;
	gpio_two_out = 1'h1;
	gpio_two_oe = 1'h1;
	bad_count = 0;
	compares = 0;
	repeat (20) @(posedge clk);
	srst <= 1'h0;
	@(posedge clk);
	rd_m(ics_pkg::ICS_OFS_CTL, 32'hffff_fff1, 32'h60);
	rd_m(ics_pkg::ICS_OFS_TRIM, 32'hffff_ffff, 32'h0);
	rd_m(ics_pkg::ICS_OFS_CFG, 32'hffff_ffff, 32'h5);
	wait_ctl(32'h8, 32'h0);
	chk({pin_one_oe, pin_one_out, pin_two_oe}, 3'h5);
	div_chk(64);
	wr(ics_pkg::ICS_OFS_TRIM, 32'hffff_ffff);
	rd_m(ics_pkg::ICS_OFS_TRIM, 32'hffff_ffff, 32'h1f);
	foreach (codes[i])
	begin
		wr(ics_pkg::ICS_OFS_TRIM, {27'h0, codes[i]});
		chk({27'h0, trim_value}, codes[i]);
		chk(trim_value < 5'sh00, codes[i][4]);
	end
	apb(1'h1, 12'h00c, 32'hffff_ffff);
	chk(errv, 1);
	apb(1'h0, 12'h00c, 32'h0);
	chk(rdv, 0);
	wr(ics_pkg::ICS_OFS_CFG, 32'h3);
	wait_ctl(32'h8, 32'h8);
	chk({pin_one_oe, pin_two_oe, pin_two_out, fast_osc_en,
		slow_osc_en}, 5'h0c);
	foreach (tmr[i])
	begin
		wr(ics_pkg::ICS_OFS_CFG, tmr[i]);
		chk({fast_osc_en, slow_osc_en}, 2'h1);
	end
	wr(ics_pkg::ICS_OFS_CFG, 32'h0b);
	chk({fast_osc_en, slow_osc_en}, 2'h2);
	wr(ics_pkg::ICS_OFS_CTL, 32'h0);
	chk({fast_osc_en, slow_osc_en}, 2'h1);
	wr(ics_pkg::ICS_OFS_CTL, 32'h60);
	wr(ics_pkg::ICS_OFS_CFG, 32'h3);
	auto_internal <= 1'h1;
	wait_ctl(32'h9, 32'h0);
	auto_internal <= 1'h0;
	wait_ctl(32'h8, 32'h8);
	wr(ics_pkg::ICS_OFS_CFG, 32'h6);
	chk({pin_one_oe, pin_two_oe, pin_two_out}, 3'h3);
	wr(ics_pkg::ICS_OFS_CFG, 32'h7);
	chk({pin_one_oe, pin_two_oe}, 2'h1);
	div_chk(64);
	wr(ics_pkg::ICS_OFS_CFG, 32'h4);
	wait_ctl(32'h8, 32'h0);
	chk({pin_one_oe, pin_one_out, pin_two_oe, pin_two_out}, 4'hb);
	wr(ics_pkg::ICS_OFS_CFG, 32'h3);
	wait_ctl(32'h8, 32'h8);
	wr(ics_pkg::ICS_OFS_CTL, 32'h71);
	wait_ctl(32'h7d, 32'h75);
	chk(fast_osc_en, 1);
	wr(ics_pkg::ICS_OFS_CTL, 32'h01);
	wait_ctl(32'h7b, 32'h03);
	chk(slow_osc_en, 1);
	// Status cannot show an internal-to-internal connect; allow a slow rise
	repeat (100) @(posedge clk);
	fast_osc_ready <= 1'h0;
	repeat (4) @(posedge clk);
	rd_m(ics_pkg::ICS_OFS_CTL, 32'h6, 32'h2);
	fast_osc_ready <= 1'h1;
	wr(ics_pkg::ICS_OFS_CFG, 32'h5);
	div_chk(256);
	wr(ics_pkg::ICS_OFS_TRIM, 32'h0f);
	srst <= 1'h1;
	repeat (3) @(posedge clk);
	srst <= 1'h0;
	@(posedge clk);
	rd_m(ics_pkg::ICS_OFS_CTL, 32'hffff_fff1, 32'h60);
	rd_m(ics_pkg::ICS_OFS_TRIM, 32'hffff_ffff, 32'h0);
	conclude();
end

endmodule

`default_nettype wire
